/* src/cic_core.sv */
`include "cic_params.svh"
`default_nettype none
module cic_core #(
  parameter int PERIPH_BITS = 8
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        timer_zero_overflow_in,
  input  wire logic [2:0]  ext_pin_in,
  input  wire logic [3:0]  upper_four_port_pins_in,
  input  wire logic        port_read_in,
  input  wire logic [PERIPH_BITS-1:0] periph_event1_in,
  input  wire logic [PERIPH_BITS-1:0] periph_event2_in,
  input  wire logic        irq_ack_in,
  input  wire logic        return_from_irq_instr_in,
  output logic             irq_high_out,
  output logic             irq_low_out,
  output logic [20:0]      irq_vector_out,
  output logic             pullup_disable_all_out,
  output logic [3:0]       port_latch_out
);
  import cic_pkg::*;

  cic_state_s s_q;
  cic_state_s s_d;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic [2:0] edge_sel;
  logic [2:0] ext_evt;
  logic [4:0] src_flag;
  logic [4:0] src_en;
  logic [4:0] src_pri;
  logic       periph_pend;
  logic       hi_pend;
  logic       lo_pend;
  logic       take_high;
  logic       take_low;

  assign acc = (avs_read_in | avs_write_in) && s_q.bus == CIC_BUS_IDLE;
  assign wr  = avs_write_in && s_q.bus == CIC_BUS_IDLE;
  assign wd  = avs_writedata_in[7:0];

  // Edge detection on the external pins, polarity per pin. [R12]
  assign edge_sel = {s_q.ctrl2[`CIC_BIT_EDGE2], s_q.ctrl2[`CIC_BIT_EDGE1],
                     s_q.ctrl2[`CIC_BIT_EDGE0]};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_edge
      assign ext_evt[g] = edge_sel[g] ? (ext_pin_in[g] & ~s_q.ext_prev[g])
                                      : (~ext_pin_in[g] & s_q.ext_prev[g]);
    end
  endgenerate

  // Sources in order: ext0, ext1, ext2, timer, port change.
  // Pin zero is fixed high priority. [R23]
  assign src_flag = {s_q.ctrl1[`CIC_BIT_PCIF], s_q.ctrl1[`CIC_BIT_TIF],
                     s_q.ctrl3[`CIC_BIT_E2IF], s_q.ctrl3[`CIC_BIT_E1IF],
                     s_q.ctrl1[`CIC_BIT_E0IF]};
  assign src_en   = {s_q.ctrl1[`CIC_BIT_PCIE], s_q.ctrl1[`CIC_BIT_TIE],
                     s_q.ctrl3[`CIC_BIT_E2IE], s_q.ctrl3[`CIC_BIT_E1IE],
                     s_q.ctrl1[`CIC_BIT_E0IE]}; // [R06] [R16]
  assign src_pri  = {s_q.ctrl2[`CIC_BIT_PCIP], s_q.ctrl2[`CIC_BIT_TIP],
                     s_q.ctrl3[`CIC_BIT_E2IP], s_q.ctrl3[`CIC_BIT_E1IP],
                     1'b1}; // [R13] [R15] [R23]

  // Peripheral sources are always low priority in priority mode; without it they raise the high request.
  assign periph_pend = |(s_q.pflag1 & s_q.penable1) |
                       |(s_q.pflag2 & s_q.penable2);

  // Level qualification; priority bits are ignored when priority is off.
  always_comb begin
    hi_pend = 1'b0;
    lo_pend = 1'b0;
    if (s_q.prio_en) begin // [R20]
      hi_pend = s_q.ctrl1[`CIC_BIT_GIE] &&
                |(src_flag & src_en & src_pri); // [R03] [R24]
      lo_pend = s_q.ctrl1[`CIC_BIT_PIE] &&
                (|(src_flag & src_en & ~src_pri) || periph_pend); // [R05]
    end else begin
      hi_pend = s_q.ctrl1[`CIC_BIT_GIE] &&
                (|(src_flag & src_en) ||
                 (s_q.ctrl1[`CIC_BIT_PIE] && periph_pend)); // [R02] [R04]
    end
  end

  // High may preempt a low service; nothing preempts a high service.
  assign take_high = hi_pend && s_q.level != CIC_SVC_HIGH; // [R24]
  assign take_low  = lo_pend && s_q.level == CIC_IDLE;

  always_comb begin
    s_d = s_q;
    s_d.ext_prev = ext_pin_in;
    s_d.port_read = upper_four_port_pins_in;
    // Bus: one cycle of waitrequest, then the answer.
    s_d.bus = acc ? CIC_BUS_DONE : CIC_BUS_IDLE;
    s_d.waitreq = !acc;
    if (wr) begin
      unique case (avs_address_in)
        `CIC_ADDR_CTRL1:    s_d.ctrl1 = wd;
        `CIC_ADDR_CTRL2:    s_d.ctrl2 = wd & `CIC_MASK_CTRL2; // [R14]
        `CIC_ADDR_CTRL3:    s_d.ctrl3 = wd & `CIC_MASK_CTRL3; // [R17]
        `CIC_ADDR_PFLAG1:   s_d.pflag1 = wd;
        `CIC_ADDR_PFLAG2:   s_d.pflag2 = wd;
        `CIC_ADDR_PENABLE1: s_d.penable1 = wd;
        `CIC_ADDR_PENABLE2: s_d.penable2 = wd;
        `CIC_ADDR_RSTCTRL:  s_d.prio_en = wd[`CIC_BIT_PRIEN];
      endcase
    end
    // Reading the port latches the pins and ends the mismatch. [R10]
    if (port_read_in) begin
      s_d.port_last = upper_four_port_pins_in;
    end
    // Hardware sets override a same-cycle software clear. [R01]
    if (timer_zero_overflow_in) begin
      s_d.ctrl1[`CIC_BIT_TIF] = 1'b1; // [R07]
    end
    if (ext_evt[0]) begin
      s_d.ctrl1[`CIC_BIT_E0IF] = 1'b1; // [R08]
    end
    if (s_q.port_last != upper_four_port_pins_in) begin
      s_d.ctrl1[`CIC_BIT_PCIF] = 1'b1; // [R09] [R10]
    end
    if (ext_evt[2]) begin
      s_d.ctrl3[`CIC_BIT_E2IF] = 1'b1; // [R17]
    end
    if (ext_evt[1]) begin
      s_d.ctrl3[`CIC_BIT_E1IF] = 1'b1; // [R17]
    end
    s_d.pflag1 = s_d.pflag1 | periph_event1_in[7:0]; // [R19]
    s_d.pflag2 = s_d.pflag2 | periph_event2_in[7:0];
    // Acknowledge takes the request and drops its level enable. [R22]
    if (irq_ack_in && s_q.req_high) begin
      s_d.level = CIC_SVC_HIGH;
      s_d.ctrl1[`CIC_BIT_GIE] = 1'b0;
    end else if (irq_ack_in && s_q.req_low) begin
      s_d.level = CIC_SVC_LOW;
      s_d.ctrl1[`CIC_BIT_PIE] = 1'b0;
    end else if (return_from_irq_instr_in) begin
      unique case (s_q.level)
        CIC_SVC_HIGH: begin
          s_d.ctrl1[`CIC_BIT_GIE] = 1'b1;
          s_d.level = CIC_IDLE;
        end
        CIC_SVC_LOW: begin
          s_d.ctrl1[s_q.prio_en ? `CIC_BIT_PIE : `CIC_BIT_GIE] = 1'b1;
          s_d.level = CIC_IDLE;
        end
        CIC_IDLE: s_d.ctrl1[`CIC_BIT_GIE] = 1'b1;
        default: ;
      endcase
    end
    s_d.req_high = take_high && !irq_ack_in;
    s_d.req_low  = take_low && !take_high && !irq_ack_in;
    // Compatibility mode sends everything to the high vector. [R21]
    s_d.vector = (take_low && !take_high) ? `CIC_VEC_LOW : `CIC_VEC_HIGH;
    s_d.pullup_dis = s_q.ctrl2[`CIC_BIT_PUDIS]; // [R11]
    s_d.rdata = 8'h00;
    if (avs_read_in && s_q.bus == CIC_BUS_IDLE) begin
      unique case (avs_address_in)
        `CIC_ADDR_CTRL1:    s_d.rdata = s_q.ctrl1;
        `CIC_ADDR_CTRL2:    s_d.rdata = s_q.ctrl2 & `CIC_MASK_CTRL2;
        `CIC_ADDR_CTRL3:    s_d.rdata = s_q.ctrl3 & `CIC_MASK_CTRL3;
        `CIC_ADDR_PFLAG1:   s_d.rdata = s_q.pflag1;
        `CIC_ADDR_PFLAG2:   s_d.rdata = s_q.pflag2;
        `CIC_ADDR_PENABLE1: s_d.rdata = s_q.penable1;
        `CIC_ADDR_PENABLE2: s_d.rdata = s_q.penable2;
        `CIC_ADDR_RSTCTRL:  s_d.rdata = {s_q.prio_en, 7'h00};
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{ctrl1: `CIC_RST_CTRL1, ctrl2: `CIC_RST_CTRL2,
               ctrl3: `CIC_RST_CTRL3, level: CIC_IDLE, bus: CIC_BUS_IDLE,
               vector: `CIC_VEC_HIGH, pullup_dis: 1'b1, waitreq: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_out       = {24'h000000, s_q.rdata};
  assign avs_waitrequest_out    = s_q.waitreq;
  assign irq_high_out           = s_q.req_high;
  assign irq_low_out            = s_q.req_low;
  assign irq_vector_out         = s_q.vector;
  assign pullup_disable_all_out = s_q.pullup_dis;
  assign port_latch_out         = s_q.port_last;

  // Flags rise the cycle after their event, whatever the enables.
  a_timer_flag_set: assert property ( // [R07]
    @(posedge clock_in) disable iff (!rst_n_in)
    timer_zero_overflow_in
    |=> s_q.ctrl1[`CIC_BIT_TIF])
    else $error("timer flag not set after overflow");

  a_port_mismatch: assert property ( // [R10]
    @(posedge clock_in) disable iff (!rst_n_in)
    (s_q.port_last != upper_four_port_pins_in) && !port_read_in
    |=> s_q.ctrl1[`CIC_BIT_PCIF])
    else $error("port change flag not held during mismatch");

  a_ctrl2_zero: assert property ( // [R14]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.bus == CIC_BUS_IDLE && avs_read_in && avs_address_in == `CIC_ADDR_CTRL2
    |=> s_q.rdata[3] == 1'b0 && s_q.rdata[1] == 1'b0)
    else $error("unimplemented bits read nonzero");

  a_gie_blocks: assert property ( // [R02]
    @(posedge clock_in) disable iff (!rst_n_in)
    !s_q.ctrl1[`CIC_BIT_GIE] && !s_q.prio_en
    |=> !s_q.req_high)
    else $error("request raised with global enable off");

  a_ack_clears: assert property ( // [R22]
    @(posedge clock_in) disable iff (!rst_n_in)
    irq_ack_in && s_q.req_high
    |=> !s_q.ctrl1[`CIC_BIT_GIE] && s_q.level == CIC_SVC_HIGH)
    else $error("global enable not cleared on acknowledge");

  a_ext0_edge: assert property ( // [R08]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.ctrl2[`CIC_BIT_EDGE0] && ext_pin_in[0] && !s_q.ext_prev[0]
    |=> s_q.ctrl1[`CIC_BIT_E0IF])
    else $error("pin zero rising edge missed");

  a_compat_vector: assert property ( // [R21]
    @(posedge clock_in) disable iff (!rst_n_in)
    !s_q.prio_en
    |=> s_q.vector == `CIC_VEC_HIGH)
    else $error("compat mode used low vector");

  a_low_blocked: assert property ( // [R05]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.prio_en && !s_q.ctrl1[`CIC_BIT_PIE]
    |=> !s_q.req_low)
    else $error("low request with low enable off");

  a_pullup_out: assert property ( // [R11]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.ctrl2[`CIC_BIT_PUDIS]
    |=> pullup_disable_all_out)
    else $error("pull-up disable not driven");

  a_ext0_fall: assert property ( // [R08]
    @(posedge clock_in) disable iff (!rst_n_in)
    !s_q.ctrl2[`CIC_BIT_EDGE0] && !ext_pin_in[0] && s_q.ext_prev[0]
    |=> s_q.ctrl1[`CIC_BIT_E0IF])
    else $error("pin zero falling edge missed");

  a_ext1_flag: assert property ( // [R17]
    @(posedge clock_in) disable iff (!rst_n_in)
    ext_evt[1]
    |=> s_q.ctrl3[`CIC_BIT_E1IF])
    else $error("pin one flag not set");

  a_ext2_flag: assert property ( // [R17]
    @(posedge clock_in) disable iff (!rst_n_in)
    ext_evt[2]
    |=> s_q.ctrl3[`CIC_BIT_E2IF])
    else $error("pin two flag not set");

  a_timer_sticky: assert property ( // [R07]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.ctrl1[`CIC_BIT_TIF] && !(wr && avs_address_in == `CIC_ADDR_CTRL1)
    |=> s_q.ctrl1[`CIC_BIT_TIF])
    else $error("timer flag dropped without a write");

  a_ext0_sticky: assert property ( // [R08]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.ctrl1[`CIC_BIT_E0IF] && !(wr && avs_address_in == `CIC_ADDR_CTRL1)
    |=> s_q.ctrl1[`CIC_BIT_E0IF])
    else $error("pin zero flag dropped without a write");

  a_port_sticky: assert property ( // [R09]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.ctrl1[`CIC_BIT_PCIF] && !(wr && avs_address_in == `CIC_ADDR_CTRL1)
    |=> s_q.ctrl1[`CIC_BIT_PCIF])
    else $error("port change flag dropped without a write");

  a_port_latch: assert property ( // [R10]
    @(posedge clock_in) disable iff (!rst_n_in)
    port_read_in
    |=> port_latch_out == $past(upper_four_port_pins_in))
    else $error("port read did not latch the pins");

  a_gieh_off: assert property ( // [R03]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.prio_en && !s_q.ctrl1[`CIC_BIT_GIE]
    |=> !irq_high_out)
    else $error("high request with high enable off");

  a_peie_compat: assert property ( // [R04]
    @(posedge clock_in) disable iff (!rst_n_in)
    !s_q.prio_en && !s_q.ctrl1[`CIC_BIT_PIE] && !(|(src_flag & src_en))
    |=> !irq_high_out)
    else $error("peripheral request with peripheral enable off");

  a_low_vector: assert property ( // [R21]
    @(posedge clock_in) disable iff (!rst_n_in)
    irq_low_out
    |-> irq_vector_out == `CIC_VEC_LOW)
    else $error("low request without the low vector");

  a_req_exclusive: assert property ( // [R24]
    @(posedge clock_in) disable iff (!rst_n_in)
    1'b1
    |-> !(irq_high_out && irq_low_out))
    else $error("high and low requests raised together");

  a_low_ack: assert property ( // [R22]
    @(posedge clock_in) disable iff (!rst_n_in)
    irq_ack_in && s_q.req_low && !s_q.req_high
    |=> !s_q.ctrl1[`CIC_BIT_PIE] && s_q.level == CIC_SVC_LOW)
    else $error("low enable not cleared on acknowledge");

  a_reti_high: assert property ( // [R22]
    @(posedge clock_in) disable iff (!rst_n_in)
    return_from_irq_instr_in && !irq_ack_in && s_q.level == CIC_SVC_HIGH
    |=> s_q.ctrl1[`CIC_BIT_GIE] && s_q.level == CIC_IDLE)
    else $error("return did not restore the high enable");

  a_reti_low: assert property ( // [R22]
    @(posedge clock_in) disable iff (!rst_n_in)
    return_from_irq_instr_in && !irq_ack_in && s_q.level == CIC_SVC_LOW
    |=> s_q.ctrl1[s_q.prio_en ? `CIC_BIT_PIE : `CIC_BIT_GIE])
    else $error("return did not restore the low enable");

  a_high_no_nest: assert property ( // [R24]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.level == CIC_SVC_HIGH
    |=> !irq_high_out && !irq_low_out)
    else $error("request raised during a high service");

  a_rd_ctrl3: assert property ( // [R17]
    @(posedge clock_in) disable iff (!rst_n_in)
    s_q.bus == CIC_BUS_IDLE && avs_read_in && avs_address_in == `CIC_ADDR_CTRL3
    |=> s_q.rdata[5] == 1'b0 && s_q.rdata[2] == 1'b0)
    else $error("unimplemented third register bits read nonzero");

  a_wr_prio: assert property ( // [R13]
    @(posedge clock_in) disable iff (!rst_n_in)
    wr && avs_address_in == `CIC_ADDR_CTRL2
    |=> s_q.ctrl2[`CIC_BIT_TIP] == $past(avs_writedata_in[2]))
    else $error("timer priority bit not written");

  a_wr_ext_en: assert property ( // [R16]
    @(posedge clock_in) disable iff (!rst_n_in)
    wr && avs_address_in == `CIC_ADDR_CTRL3
    |=> s_q.ctrl3[4:3] == $past(avs_writedata_in[4:3]))
    else $error("pin enables not written");

  a_wr_ext_pri: assert property ( // [R15]
    @(posedge clock_in) disable iff (!rst_n_in)
    wr && avs_address_in == `CIC_ADDR_CTRL3
    |=> s_q.ctrl3[7:6] == $past(avs_writedata_in[7:6]))
    else $error("pin priorities not written");

  a_prio_write: assert property ( // [R20]
    @(posedge clock_in) disable iff (!rst_n_in)
    wr && avs_address_in == `CIC_ADDR_RSTCTRL
    |=> s_q.prio_en == $past(avs_writedata_in[7]))
    else $error("priority enable not written");

  a_periph_flag: assert property ( // [R19]
    @(posedge clock_in) disable iff (!rst_n_in)
    periph_event1_in[0]
    |=> s_q.pflag1[0])
    else $error("peripheral flag not set");
endmodule : cic_core
`default_nettype wire

/* src/cic_params.svh */
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH
// Overview of operation
// [R01] Flags set on their event whatever the enable and global bits say.
// [R02] Without priority, control bit 7 is the global enable for all sources.
// [R03] With priority, control bit 7 enables high-priority sources only.
// [R04] Without priority, control bit 6 gates every peripheral source.
// [R05] With priority, control bit 6 enables low-priority peripheral sources.
// [R06] Control bits 5, 4, 3 enable timer, pin zero and port-change sources.
// [R07] Control bit 2 sets on timer overflow and holds until written 0.
// [R08] Control bit 1 sets on pin zero event and holds until cleared.
// [R09] Control bit 0 sets when any upper four port pins change.
// [R10] Port mismatch keeps setting the change flag until the port is read.
// [R11] Second register bit 7 disables all pull-ups; else latches decide.
// [R12] Second register bits 6, 5, 4 pick rising or falling edge per pin.
// [R13] Second register bits 2 and 0 give timer and port-change priority.
// [R14] Second register bits 3 and 1 always read zero.
// [R15] Third register bits 7, 6 give priority of pins two and one.
// [R16] Third register bits 4, 3 enable pins two and one.
// [R17] Third register bits 1, 0 flag pins two, one; bits 5, 2 read 0.
// [R18] Software clears a flag before enabling and after servicing it.
// [R19] Peripheral flags live in two separate peripheral flag registers.
// [R20] Priority-enable bit 7 of reset control selects priority mode.
// [R21] High requests vector to 000008h, low to 000018h; compat all 000008h.
// [R22] Taking an interrupt clears that level's global enable; return sets it. After high preempts low, the low return sets bit 7, not bit 6.
// [R23] Pin zero has no priority bit and is always high priority.
// [R24] Request needs flag, enable and level enable; high preempts low.
`define CIC_ADDR_CTRL1     3'h0
`define CIC_ADDR_CTRL2     3'h1
`define CIC_ADDR_CTRL3     3'h2
`define CIC_ADDR_PFLAG1    3'h3
`define CIC_ADDR_PFLAG2    3'h4
`define CIC_ADDR_PENABLE1  3'h5
`define CIC_ADDR_PENABLE2  3'h6
`define CIC_ADDR_RSTCTRL   3'h7
`define CIC_RST_CTRL1      8'h00
`define CIC_RST_CTRL2      8'hF5
`define CIC_RST_CTRL3      8'hC0
`define CIC_MASK_CTRL2     8'hF5
`define CIC_MASK_CTRL3     8'hDB
`define CIC_BIT_GIE        7
`define CIC_BIT_PIE        6
`define CIC_BIT_TIE        5
`define CIC_BIT_E0IE       4
`define CIC_BIT_PCIE       3
`define CIC_BIT_TIF        2
`define CIC_BIT_E0IF       1
`define CIC_BIT_PCIF       0
`define CIC_BIT_PUDIS      7
`define CIC_BIT_EDGE0      6
`define CIC_BIT_EDGE1      5
`define CIC_BIT_EDGE2      4
`define CIC_BIT_TIP        2
`define CIC_BIT_PCIP       0
`define CIC_BIT_E2IP       7
`define CIC_BIT_E1IP       6
`define CIC_BIT_E2IE       4
`define CIC_BIT_E1IE       3
`define CIC_BIT_E2IF       1
`define CIC_BIT_E1IF       0
`define CIC_BIT_PRIEN      7
`define CIC_VEC_HIGH       21'h000008
`define CIC_VEC_LOW        21'h000018
`endif

/* src/cic_pkg.sv */
`default_nettype none
package cic_pkg;
  typedef enum logic [1:0] {
    CIC_IDLE,
    CIC_SVC_LOW,
    CIC_SVC_HIGH
  } cic_level_e;
  typedef enum logic [1:0] {
    CIC_BUS_IDLE,
    CIC_BUS_DONE
  } cic_bus_e;
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  ctrl3;
    logic [7:0]  pflag1;
    logic [7:0]  pflag2;
    logic [7:0]  penable1;
    logic [7:0]  penable2;
    logic        prio_en;
    logic [3:0]  port_last;
    logic [2:0]  ext_prev;
    cic_level_e  level;
    cic_bus_e    bus;
    logic [7:0]  rdata;
    logic        req_high;
    logic        req_low;
    logic [20:0] vector;
    logic        pullup_dis;
    logic [3:0]  port_read;
    logic        waitreq;
  } cic_state_s;
endpackage : cic_pkg
`default_nettype wire

/* dv/cic_core_model.sv */
`default_nettype none
module cic_core_model (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic irq_high_in,
  input  wire logic irq_low_in,
  input  wire logic serve_in,
  output logic      irq_ack_out,
  output logic      return_out
);
  logic busy_q;
  // The core takes one request per service and returns once told to stop.
  // Nesting is not modelled, which keeps the bench's expectations simple.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q      <= 1'b0;
      irq_ack_out <= 1'b0;
      return_out  <= 1'b0;
    end else begin
      irq_ack_out <= 1'b0;
      return_out  <= 1'b0;
      if (serve_in && !busy_q && (irq_high_in || irq_low_in)) begin
        irq_ack_out <= 1'b1;
        busy_q      <= 1'b1;
      end else if (!serve_in && busy_q) begin
        return_out <= 1'b1;
        busy_q     <= 1'b0;
      end
    end
  end
endmodule : cic_core_model
`default_nettype wire

/* dv/test_core_interrupt_control_regs.sv */
`include "cic_params.svh"
`default_nettype none
module test_core_interrupt_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [2:0]  addr     = 3'h0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        tmr      = 1'b0;
  logic        pread    = 1'b0;
  logic        serve    = 1'b0;
  logic [2:0]  ext      = 3'h0;
  logic [7:0]  pev      = 8'h00;
  logic [3:0]  pins     = 4'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic        wait_rq;
  logic        ack;
  logic        reti;
  logic        irq_hi;
  logic        irq_lo;
  logic        pud;
  logic [3:0]  latch;
  logic [20:0] vec;
  int          n_fail   = 0;
  int          compares = 0;
  cic_core u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_rq), .timer_zero_overflow_in(tmr),
    .ext_pin_in(ext), .upper_four_port_pins_in(pins),
    .port_read_in(pread), .periph_event1_in(pev),
    .periph_event2_in(8'h00), .irq_ack_in(ack),
    .return_from_irq_instr_in(reti), .irq_high_out(irq_hi),
    .irq_low_out(irq_lo), .irq_vector_out(vec),
    .pullup_disable_all_out(pud), .port_latch_out(latch));
  cic_core_model u_core (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .irq_high_in(irq_hi), .irq_low_in(irq_lo), .serve_in(serve),
    .irq_ack_out(ack), .return_out(reti));
  always #10 clock_in = ~clock_in;
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  // The request stands until the edge at which waitrequest is seen low;
  // read data is taken at that same edge, and only then is it released.
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clock_in);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= {24'h0, v};
    @(posedge clock_in);
    while (wait_rq !== 1'b0 && k < 50) begin
      @(posedge clock_in);
      k++;
    end
    if (k == 50) chk("waitrequest", 32'h0, 32'h1);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [2:0] a,
                      input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, d);
  endtask : rchk
  task automatic wait_req(input logic hi, input logic lo);
    int k;
    k = 0;
    while ((irq_hi !== hi || irq_lo !== lo) && k < 20) begin
      @(negedge clock_in);
      k++;
    end
    chk("irq_high", 32'(hi), 32'(irq_hi));
    chk("irq_low", 32'(lo), 32'(irq_lo));
  endtask : wait_req
  task automatic drive(input logic [2:0] e, input logic [3:0] p,
                       input logic t, input logic r);
    @(posedge clock_in);
    ext   <= e;
    pins  <= p;
    tmr   <= t;
    pread <= r;
    @(posedge clock_in);
    tmr   <= 1'b0;
    pread <= 1'b0;
    tick(2);
  endtask : drive
  task automatic t_reset();
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h00);
    rchk("ctrl2", `CIC_ADDR_CTRL2, 8'hF5);
    rchk("ctrl3", `CIC_ADDR_CTRL3, 8'hC0);
    chk("pullup", 32'h1, 32'(pud));
  endtask : t_reset
  task automatic t_poll();
    drive(3'h5, 4'h0, 1'b1, 1'b0);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h06);
    chk("irq_high", 32'h0, 32'(irq_hi));
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h00);
  endtask : t_poll
  task automatic t_compat();
    bus(1'b1, `CIC_ADDR_CTRL1, 8'hA0);
    drive(ext, pins, 1'b1, 1'b0);
    wait_req(1'b1, 1'b0);
    chk("vector", 32'h8, 32'(vec));
    @(posedge clock_in);
    serve <= 1'b1;
    wait_req(1'b0, 1'b0);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h24);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h20);
    serve <= 1'b0;
    tick(3);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'hA0);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
  endtask : t_compat
  task automatic t_prio();
    bus(1'b1, `CIC_ADDR_RSTCTRL, 8'h80);
    bus(1'b1, `CIC_ADDR_CTRL2, 8'hE0);
    bus(1'b1, `CIC_ADDR_CTRL3, 8'h08);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'hC0);
    drive(3'h7, pins, 1'b0, 1'b0);
    wait_req(1'b0, 1'b1);
    chk("vector", 32'h18, 32'(vec));
    drive(3'h3, pins, 1'b0, 1'b0);
    rchk("ctrl3", `CIC_ADDR_CTRL3, 8'h0B);
    bus(1'b1, `CIC_ADDR_CTRL3, 8'h00);
    drive(3'h5, pins, 1'b0, 1'b0);
    rchk("ctrl3", `CIC_ADDR_CTRL3, 8'h00);
    bus(1'b1, `CIC_ADDR_CTRL3, 8'h48);
    drive(3'h7, pins, 1'b0, 1'b0);
    wait_req(1'b1, 1'b0);
    chk("vector", 32'h8, 32'(vec));
    bus(1'b1, `CIC_ADDR_CTRL3, 8'h00);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    bus(1'b1, `CIC_ADDR_RSTCTRL, 8'h00);
    bus(1'b1, `CIC_ADDR_CTRL2, 8'hF5);
  endtask : t_prio
  task automatic t_pullup();
    bus(1'b1, `CIC_ADDR_CTRL2, 8'hFF);
    rchk("ctrl2", `CIC_ADDR_CTRL2, 8'hF5);
    chk("pullup", 32'h1, 32'(pud));
    bus(1'b1, `CIC_ADDR_CTRL2, 8'h00);
    rchk("ctrl2", `CIC_ADDR_CTRL2, 8'h00);
    chk("pullup", 32'h0, 32'(pud));
    bus(1'b1, `CIC_ADDR_CTRL2, 8'hF5);
  endtask : t_pullup
  task automatic t_port();
    drive(ext, 4'h0, 1'b0, 1'b1);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    drive(ext, 4'h5, 1'b0, 1'b0);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h01);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h01);
    drive(ext, 4'h5, 1'b0, 1'b1);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    rchk("ctrl1", `CIC_ADDR_CTRL1, 8'h00);
    chk("port_latch", 32'h5, 32'(latch));
  endtask : t_port
  task automatic t_periph();
    bus(1'b1, `CIC_ADDR_PENABLE1, 8'h01);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'hC0);
    @(posedge clock_in);
    pev <= 8'h01;
    @(posedge clock_in);
    pev <= 8'h00;
    wait_req(1'b1, 1'b0);
    rchk("pflag1", `CIC_ADDR_PFLAG1, 8'h01);
    bus(1'b1, `CIC_ADDR_CTRL1, 8'h00);
    bus(1'b1, `CIC_ADDR_PFLAG1, 8'h00);
    rchk("pflag1", `CIC_ADDR_PFLAG1, 8'h00);
  endtask : t_periph
  initial begin
    tick(8);
    rst_n_in <= 1'b1;
    t_reset();
    t_poll();
    t_compat();
    t_prio();
    t_pullup();
    t_port();
    t_periph();
    print_verdict();
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule : test_core_interrupt_control_regs
`default_nettype wire
